// [design/nand_host_ctrl.sv]
// Host controller that drives a byte-wide NAND flash through its strobe pins.
`timescale 1ns/10ps
`include "nand_host_defines.svh"
// Overview of operation
// - Second-half program issues its pointer command right before data input.
// - Scan reads original marks; controller never erases them itself.
// - Status failure after program or erase is reported for block retirement.
// - Error correction is left to the user side of the controller.
// - Chip enable is held inactive long enough to break a sequential read.
// - Program sends data input command, three addresses, data, then confirm.
module nand_host_ctrl #(
  parameter int STROBE_DIV = 1
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_start,
  input  wire nand_host_pkg::op_kind_t i_op,
  input  wire nand_host_pkg::ptr_area_t i_area,
  input  wire logic [23:0]            i_addr,
  input  wire logic [9:0]             i_len,
  input  wire logic [7:0]             i_wdata,
  output logic                        o_wready,
  output logic [7:0]                  o_rdata,
  output logic                        o_rvalid,
  input  wire logic                   i_rready,
  output logic                        o_busy,
  output logic                        o_done,
  output logic                        o_fail,
  output logic                        o_bad_mark,
  output logic                        o_cle,
  output logic                        o_ale,
  output logic                        o_ce_b,
  output logic                        o_we_b,
  output logic                        o_re_b,
  output logic [7:0]                  o_io,
  output logic                        o_io_oe,
  input  wire logic [7:0]             i_io,
  input  wire logic                   i_ready_pin
);
  import nand_host_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_PTR = 4'h1, S_CMD = 4'h3, S_ADDR = 4'h2, S_DATA = 4'h6, S_CONF = 4'h7,
    S_WB = 4'h5, S_WAIT = 4'h4, S_RDAT = 4'hC, S_STCMD = 4'hD, S_STRD = 4'hF, S_BREAK = 4'hE
  } st_t;

  logic        rst_s1_r, rst_b_r;
  logic        rdy_s1_r, rdy_r;
  logic [7:0]  io_s1_r, io_r;
  st_t         st_r;
  ptr_area_t   ptr_copy_r;
  op_kind_t    op_r;
  ptr_area_t   area_r;
  logic [23:0] addr_r;
  logic [9:0]  len_r, col_r;
  logic [1:0]  acnt_r;
  logic [1:0]  ph_r;
  logic [3:0]  tcnt_r;
  logic        phase_en;
  logic        buf_ready;
  logic        rd_push;

  function automatic logic [7:0] area_cmd(input ptr_area_t a);
    unique case (a)
      PTR_SECOND: area_cmd = `CMD_PTR_SECOND;
      PTR_SPARE:  area_cmd = `CMD_PTR_SPARE;
      default:    area_cmd = `CMD_PTR_FIRST;
    endcase
  endfunction : area_cmd

  function automatic logic [9:0] area_base(input ptr_area_t a);
    unique case (a)
      PTR_SECOND: area_base = `COL_SECOND_BASE;
      PTR_SPARE:  area_base = `COL_SPARE_BASE;
      default:    area_base = 10'h000;
    endcase
  endfunction : area_base

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_r <= 1'b0;
      rst_b_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_b_r  <= rst_s1_r;
    end
  end

  always_ff @(posedge i_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      rdy_s1_r <= 1'b0;
      rdy_r    <= 1'b0;
      io_s1_r  <= 8'h00;
      io_r     <= 8'h00;
    end else begin
      rdy_s1_r <= i_ready_pin;
      rdy_r    <= rdy_s1_r;
      io_s1_r  <= i_io;
      io_r     <= io_s1_r;
    end
  end

  // Each write pin cycle uses two phases: strobe low, then strobe high.
  always_ff @(posedge i_clk or negedge rst_b_r) begin
    if (!rst_b_r) ph_r <= 2'h0;
    else ph_r <= (ph_r == 2'h3) ? 2'h0 : ph_r + 2'h1;
  end
  assign phase_en = (STROBE_DIV <= 1) ? 1'b1 : (ph_r == 2'h3);

  // A byte is taken only once it has crossed both input flip-flops.
  assign rd_push = (st_r == S_RDAT) && phase_en && !o_re_b && !o_ce_b &&
                   (tcnt_r == 4'(`PIN_SYNC_CYC));

  nand_skid_buf #(.WIDTH(8)) u_buf (
    .i_clk   (i_clk),
    .i_rst_b (rst_b_r),
    .i_data  (io_r),
    .i_valid (rd_push),
    .o_ready (buf_ready),
    .o_data  (o_rdata),
    .o_valid (o_rvalid),
    .i_ready (i_rready)
  );

  always_ff @(posedge i_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      st_r       <= S_IDLE;
      ptr_copy_r <= PTR_FIRST;
      op_r       <= OP_READ;
      area_r     <= PTR_FIRST;
      addr_r     <= 24'h000000;
      len_r      <= 10'h000;
      col_r      <= 10'h000;
      acnt_r     <= 2'h0;
      tcnt_r     <= 4'h0;
      o_busy     <= 1'b0;
      o_done     <= 1'b0;
      o_fail     <= 1'b0;
      o_bad_mark <= 1'b0;
      o_wready   <= 1'b0;
      o_cle      <= 1'b0;
      o_ale      <= 1'b0;
      o_ce_b     <= 1'b1;
      o_we_b     <= 1'b1;
      o_re_b     <= 1'b1;
      o_io       <= 8'h00;
      o_io_oe    <= 1'b0;
    end else begin
      o_done   <= 1'b0;
      o_wready <= 1'b0;
      unique case (st_r)
        S_IDLE: if (i_start) begin
          op_r   <= i_op;
          area_r <= i_area;
          addr_r <= i_addr;
          len_r  <= i_len;
          col_r  <= area_base(i_area) + {2'h0, i_addr[7:0]};
          o_busy <= 1'b1;
          o_fail <= 1'b0;
          o_bad_mark <= 1'b0;
          o_ce_b <= 1'b0;
          // Persistent pointers need no reissue; second half always needs one.
          if ((i_op == OP_READ || i_op == OP_PROGRAM) &&
              (i_area == PTR_SECOND || i_area != ptr_copy_r)) st_r <= S_PTR;
          else st_r <= S_CMD;
        end
        S_PTR: if (phase_en) begin
          o_cle <= 1'b1;
          o_io_oe <= 1'b1;
          o_io <= area_cmd(area_r);
          o_we_b <= ~o_we_b;
          if (!o_we_b) begin
            ptr_copy_r <= area_r;
            st_r <= S_CMD;
          end
        end
        S_CMD: if (phase_en) begin
          o_cle <= 1'b1;
          o_io_oe <= 1'b1;
          unique case (op_r)
            OP_PROGRAM: o_io <= `CMD_DATA_IN;
            OP_ERASE:   o_io <= `CMD_ERASE_SETUP;
            OP_RESET:   o_io <= `CMD_RESET;
            OP_STATUS:  o_io <= `CMD_READ_STATUS;
            default:    o_io <= area_cmd(area_r);
          endcase
          o_we_b <= ~o_we_b;
          if (!o_we_b) begin
            acnt_r <= (op_r == OP_ERASE) ? 2'h1 : 2'h0;
            st_r <= (op_r == OP_RESET) ? S_WB : (op_r == OP_STATUS) ? S_STRD : S_ADDR;
          end
        end
        S_ADDR: if (phase_en) begin
          // Latch enables drop one phase after the last strobe rise to keep their hold.
          o_cle <= 1'b0;
          o_ale <= 1'b1;
          o_io <= addr_r[{acnt_r, 3'h0} +: 8];
          o_we_b <= ~o_we_b;
          if (!o_we_b) begin
            acnt_r <= acnt_r + 2'h1;
            if (acnt_r == 2'h2) begin
              st_r <= (op_r == OP_PROGRAM) ? S_DATA : (op_r == OP_ERASE) ? S_CONF : S_WB;
            end
          end
        end
        S_DATA: if (phase_en) begin
          o_ale <= 1'b0;
          o_we_b <= ~o_we_b;
          // The byte goes out as the strobe falls and stands over its rise.
          if (o_we_b) begin
            o_io <= i_wdata;
            o_wready <= 1'b1;
          end else begin
            len_r <= len_r - 10'h001;
            col_r <= col_r + 10'h001;
            if (len_r <= 10'h001) st_r <= S_CONF;
          end
        end
        S_CONF: if (phase_en) begin
          o_ale <= 1'b0;
          o_cle <= 1'b1;
          o_io <= (op_r == OP_ERASE) ? `CMD_ERASE_CONFIRM : `CMD_PROG_CONFIRM;
          o_we_b <= ~o_we_b;
          if (!o_we_b) begin
            st_r <= S_WB;
          end
        end
        S_WB: begin
          o_cle <= 1'b0;
          o_ale <= 1'b0;
          o_io_oe <= 1'b0;
          if (tcnt_r == 4'(`WB_CYC)) begin
            tcnt_r <= 4'h0;
            st_r <= S_WAIT;
          end else tcnt_r <= tcnt_r + 4'h1;
        end
        S_WAIT: if (rdy_r) begin
          if (area_r == PTR_SECOND) ptr_copy_r <= PTR_FIRST;
          if (op_r == OP_RESET) ptr_copy_r <= PTR_FIRST;
          unique case (op_r)
            OP_READ:  st_r <= S_RDAT;
            OP_RESET: st_r <= S_BREAK;
            default:  st_r <= S_STCMD;
          endcase
        end
        S_RDAT: if (phase_en) begin
          if (o_re_b) begin
            if (buf_ready) o_re_b <= 1'b0;
            tcnt_r <= 4'h0;
          end else if (tcnt_r == 4'(`PIN_SYNC_CYC)) begin
            o_re_b <= 1'b1;
            tcnt_r <= 4'h0;
            if (col_r == `BAD_MARK_COL && io_r != `ERASED_BYTE &&
                addr_r[23:13] != 11'h000) o_bad_mark <= 1'b1;
            col_r <= col_r + 10'h001;
            len_r <= len_r - 10'h001;
            if (len_r <= 10'h001) st_r <= S_BREAK;
          end else tcnt_r <= tcnt_r + 4'h1;
        end
        S_STCMD: if (phase_en) begin
          o_cle <= 1'b1;
          o_io_oe <= 1'b1;
          o_io <= `CMD_READ_STATUS;
          o_we_b <= ~o_we_b;
          if (!o_we_b) begin
            st_r <= S_STRD;
          end
        end
        S_STRD: if (phase_en) begin
          o_cle <= 1'b0;
          o_io_oe <= 1'b0;
          o_re_b <= 1'b0;
          // Status is taken once it has crossed both input flip-flops.
          if (o_re_b) tcnt_r <= 4'h0;
          else if (tcnt_r == 4'(`PIN_SYNC_CYC)) begin
            if (op_r != OP_STATUS) o_fail <= io_r[`STATUS_FAIL_BIT];
            tcnt_r <= 4'h0;
            st_r <= S_BREAK;
          end else tcnt_r <= tcnt_r + 4'h1;
        end
        S_BREAK: begin
          o_ce_b <= 1'b1;
          o_re_b <= 1'b1;
          o_io_oe <= 1'b0;
          if (tcnt_r == 4'(`BREAK_CYC)) begin
            tcnt_r <= 4'h0;
            o_busy <= 1'b0;
            o_done <= 1'b1;
            st_r <= S_IDLE;
          end else tcnt_r <= tcnt_r + 4'h1;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule : nand_host_ctrl

// [design/nand_host_defines.svh]
// Command codes, timing figures and page geometry for the flash host controller.
`ifndef NAND_HOST_DEFINES_SVH
`define NAND_HOST_DEFINES_SVH
`define CMD_PTR_FIRST     8'h00
`define CMD_PTR_SECOND    8'h01
`define CMD_PTR_SPARE     8'h50
`define CMD_READ_STATUS   8'h70
`define CMD_DATA_IN       8'h80
`define CMD_PROG_CONFIRM  8'h10
`define CMD_ERASE_SETUP   8'h60
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_RESET         8'hFF
`define CLK_PERIOD_NS     100
`define SERIAL_READ_BREAK_HOLD_NS 100
`define WRITE_HIGH_TO_BUSY_NS     100
`define BREAK_CYC  (((`SERIAL_READ_BREAK_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 1)
`define WB_CYC     (((`WRITE_HIGH_TO_BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 1)
`define BAD_MARK_COL 10'h205
`define ERASED_BYTE  8'hFF
`define COL_SECOND_BASE 10'h100
`define COL_SPARE_BASE  10'h200
`define PIN_SYNC_CYC    2
`define STATUS_FAIL_BIT 0
`endif

// [design/nand_host_pkg.sv]
// Types shared by the flash host controller.
package nand_host_pkg;
  typedef enum logic [1:0] {PTR_FIRST = 2'h0, PTR_SECOND = 2'h1, PTR_SPARE = 2'h2} ptr_area_t;
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_PROGRAM = 3'h1, OP_ERASE = 3'h2, OP_RESET = 3'h3, OP_STATUS = 3'h4
  } op_kind_t;
endpackage : nand_host_pkg

// [design/nand_skid_buf.sv]
// Two-entry valid/ready buffer that carries read bytes towards the user.
`timescale 1ns/10ps
module nand_skid_buf #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic [WIDTH-1:0]      o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  logic [WIDTH-1:0] mem_r [2];
  logic             wptr_r;
  logic             rptr_r;
  logic [1:0]       cnt_r;
  logic             push;
  logic             pop;

  assign push    = i_valid && (cnt_r != 2'h2);
  assign pop     = o_valid && i_ready;
  assign o_ready = (cnt_r != 2'h2);
  assign o_valid = (cnt_r != 2'h0);
  assign o_data  = mem_r[rptr_r];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      cnt_r  <= 2'h0;
    end else begin
      if (push) wptr_r <= ~wptr_r;
      if (pop) rptr_r <= ~rptr_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) mem_r[wptr_r] <= i_data;
  end
endmodule : nand_skid_buf

// [tb/nand_flash_model.sv]
// Behavioural flash device answering the host controller pins.
`timescale 1ns/10ps
module nand_flash_model (
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_ce_b,
  input  wire logic       i_we_b,
  input  wire logic       i_re_b,
  input  wire logic [7:0] i_io,
  output logic      [7:0] o_io,
  output logic            o_ready
);
  int ptr = 0, col = 0, nadr = 0, row = 0;
  logic stat = 1'b0, bad = 1'b0, fail = 1'b0;
  logic [7:0] cmd_q[$], wr_q[$];
  initial {o_io, o_ready} = 9'h001;
  task automatic go_busy(input int ns);
    o_ready = 1'b0;
    o_ready <= #(ns) 1'b1;
  endtask : go_busy
  always @(posedge i_we_b) if (!i_ce_b) begin
    if (i_cle) begin
      cmd_q.push_back(i_io);
      stat = i_io == 8'h70;
      {nadr, row} = '0;
      if (i_io inside {8'h00, 8'h01, 8'h50}) ptr = i_io == 8'h50 ? 512 : i_io * 256;
      if (i_io inside {8'h10, 8'hD0, 8'hFF}) begin
        go_busy(i_io == 8'hD0 ? 3000 : 1000);
        if (ptr == 256) ptr = 0;
      end
    end else if (i_ale) begin
      if (nadr == 0) col = ptr + (ptr == 512 ? i_io[3:0] : i_io);
      else row += i_io << (8 * nadr - 8);
      nadr++;
      if (nadr == 3 && cmd_q[$] inside {8'h00, 8'h01, 8'h50}) begin
        go_busy(1500);
        if (ptr == 256) ptr = 0;
      end
    end else wr_q.push_back(i_io);
  end
  always @(negedge i_re_b) if (!i_ce_b) begin
    if (stat) o_io = {7'h60, fail};
    else o_io = col != 517 ? col[7:0] : (bad && row >= 32 ? 8'h00 : 8'hFF);
    col++;
  end
  // The bus is inverted 30 ns after each read strobe rises, so stale data must not look valid.
  always @(posedge i_re_b) o_io <= #30 ~o_io;
endmodule : nand_flash_model

// [tb/nand_host_ctrl_props.sv]
// Concurrent checks on the flash host controller pins and handshake.
`timescale 1ns/10ps
module nand_host_checker (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_cle,
  input wire logic o_ale,
  input wire logic o_ce_b,
  input wire logic o_we_b,
  input wire logic o_re_b,
  input wire logic o_io_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_cmd;
    o_cle && !o_we_b ##1 o_we_b;
  endsequence
  a_done_once: assert property (o_done |=> !o_done) else $error("done too long");
  a_busy_ends: assert property (o_done |-> !o_busy) else $error("busy after done");
  a_start_taken: assert property (i_start && !o_busy |=> o_busy) else $error("start lost");
  a_pins_apart: assert property (!(o_cle && o_ale)) else $error("cle with ale");
  a_drive_write: assert property (!o_we_b |-> o_io_oe) else $error("write undriven");
  a_read_float: assert property (!o_re_b |-> !o_io_oe && o_we_b) else $error("drive in read");
  a_break_hold: assert property (o_done |-> o_ce_b && $past(o_ce_b)) else $error("ce short");
  a_cmd_gap: assert property (s_cmd |-> o_re_b) else $error("read after command");
endmodule : nand_host_checker
bind nand_host_ctrl nand_host_checker i_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start),
  .o_busy(o_busy), .o_done(o_done), .o_cle(o_cle), .o_ale(o_ale), .o_ce_b(o_ce_b),
  .o_we_b(o_we_b), .o_re_b(o_re_b), .o_io_oe(o_io_oe));

// [tb/tb_top.sv]
// Self-checking bench: host controller against a behavioural flash device.
`timescale 1ns/10ps
module tb_top;
  import nand_host_pkg::*;
  logic        i_clk, i_rst_b, i_start, i_rready, o_rvalid, o_wready, o_busy, o_done, rdy;
  logic        o_fail, o_bad_mark, o_cle, o_ale, o_ce_b, o_we_b, o_re_b, o_io_oe;
  logic [7:0]  i_wdata, o_rdata, o_io, i_io;
  logic [23:0] i_addr;
  logic [9:0]  i_len;
  op_kind_t    i_op;
  ptr_area_t   i_area, ptr;
  int          err_count, n_tests, seed, k;
  logic [7:0]  got_q[$], sent_q[$];
  nand_host_ctrl i_dut (.i_clk, .i_rst_b, .i_start, .i_op, .i_area, .i_addr, .i_len, .i_wdata,
    .o_wready, .o_rdata, .o_rvalid, .i_rready, .o_busy, .o_done, .o_fail, .o_bad_mark, .o_cle,
    .o_ale, .o_ce_b, .o_we_b, .o_re_b, .o_io, .o_io_oe, .i_io, .i_ready_pin(rdy));
  nand_flash_model i_mdl (.i_cle(o_cle), .i_ale(o_ale), .i_ce_b(o_ce_b), .i_we_b(o_we_b),
    .i_re_b(o_re_b), .i_io(o_io), .o_io(i_io), .o_ready(rdy));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #1000000;
    err_count++;
    summarize();
  end
  always @(posedge i_clk) begin
    if (o_rvalid === 1'b1 && i_rready) got_q.push_back(o_rdata);
    if (o_wready === 1'b1) sent_q.push_back(i_wdata);
    if (o_wready === 1'b1) i_wdata <= #50 8'($random(seed));
  end
  always @(negedge i_clk) i_rready <= ($random(seed) & 3) != 0;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input op_kind_t op, input ptr_area_t a, input int col, input int blk,
                     input int n);
    int base, c;
    logic [7:0] exp_c[$];
    i_mdl.cmd_q.delete();
    i_mdl.wr_q.delete();
    got_q.delete();
    sent_q.delete();
    if (a == PTR_SPARE) col = col & 7;
    base = a == PTR_SECOND ? 256 : (a == PTR_SPARE ? 512 : 0);
    i_op = op;
    i_area = a;
    i_addr = {blk[10:0], 5'h00, col[7:0]};
    i_len = n[9:0];
    i_start = 1'b1;
    @(negedge i_clk) i_start = 1'b0;
    for (k = 0; k < 5000 && o_done !== 1'b1; k++) @(negedge i_clk);
    chk(k < 5000, 1);
    for (int w = 0; w < 50 && op == OP_READ && got_q.size() < n; w++) @(negedge i_clk);
    if (op == OP_READ) begin
      chk(got_q.size(), n);
      foreach (got_q[j]) begin
        c = base + col + j;
        chk(got_q[j], c == 517 ? (i_mdl.bad && blk ? 8'h00 : 8'hFF) : c[7:0]);
      end
      chk(o_bad_mark, i_mdl.bad && blk && base + col <= 517 && base + col + n > 517);
    end else begin
      if (op == OP_PROGRAM && (a != ptr || a == PTR_SECOND))
        exp_c = {a == PTR_SECOND ? 8'h01 : (a == PTR_SPARE ? 8'h50 : 8'h00)};
      case (op)
        OP_PROGRAM: exp_c = {exp_c, 8'h80, 8'h10, 8'h70};
        OP_ERASE: exp_c = {8'h60, 8'hD0, 8'h70};
        OP_RESET: exp_c = {8'hFF};
        default: exp_c = {8'h70};
      endcase
      chk(i_mdl.cmd_q.size(), exp_c.size());
      foreach (exp_c[j]) chk(i_mdl.cmd_q[j], exp_c[j]);
      chk(o_fail, i_mdl.fail && op inside {OP_PROGRAM, OP_ERASE});
    end
    if (op == OP_PROGRAM) chk(i_mdl.wr_q.size(), n);
    if (op == OP_PROGRAM) foreach (sent_q[j]) chk(i_mdl.wr_q[j], sent_q[j]);
    if (a == PTR_SECOND || op == OP_RESET) ptr = PTR_FIRST;
    else if (op inside {OP_READ, OP_PROGRAM}) ptr = a;
  endtask : run
  task automatic summarize();
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  initial begin
    seed = 14745;
    {err_count, n_tests} = '0;
    {i_rst_b, i_start, i_wdata, i_addr, i_len, i_rready} = '0;
    i_op = OP_READ;
    i_area = PTR_FIRST;
    ptr = PTR_FIRST;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk) i_rst_b = 1'b1;
    repeat (3) @(negedge i_clk);
    run(OP_READ, PTR_FIRST, 16, 1, 4);
    run(OP_READ, PTR_SECOND, 254, 1, 3);
    run(OP_READ, PTR_FIRST, 0, 1, 2);
    run(OP_PROGRAM, PTR_SECOND, 250, 2, 9);
    run(OP_PROGRAM, PTR_SPARE, 2, 2, 3);
    run(OP_PROGRAM, PTR_SPARE, 4, 2, 2);
    run(OP_READ, PTR_SPARE, 3, 2, 4);
    run(OP_READ, PTR_SECOND, 8, 2, 2);
    run(OP_RESET, ptr, 0, 0, 1);
    run(OP_PROGRAM, PTR_FIRST, 7, 2, 2);
    i_mdl.bad = 1'b1;
    run(OP_READ, PTR_SPARE, 5, 3, 1);
    run(OP_READ, PTR_SPARE, 5, 0, 1);
    i_mdl.fail = 1'b1;
    run(OP_PROGRAM, PTR_FIRST, 0, 4, 2);
    run(OP_ERASE, ptr, 0, 5, 1);
    run(OP_STATUS, ptr, 0, 5, 1);
    repeat (6) begin
      k = $random(seed) & 3;
      run(OP_READ, k == 0 ? PTR_SPARE : (k == 1 ? PTR_SECOND : PTR_FIRST), $random(seed) & 255,
          $random(seed) & 7, ($random(seed) & 7) + 1);
    end
    summarize();
  end
endmodule : tb_top
